// File: rtl/stl_pkg.sv
// Package for the source monitor and transfer logic.
// Assumes one 40 MHz clock and measurements already in range units.
package stl_pkg;

    // ==========================================================
    // Widths and encodings
    localparam int STL_VW = 16;
    localparam int STL_FW = 16;
    localparam int STL_QW = 32;
    localparam logic [3:0] STL_VSTEP_DEF = 4'h3;
    localparam logic [3:0] STL_FSTEP_DEF = 4'h3;
    localparam int STL_V_PCT_BASE = 4;
    localparam int STL_V_PCT_STEP = 2;
    localparam int STL_F_PCT_BASE = 2;
    localparam int STL_F_PCT_STEP = 1;
    localparam int STL_V_PCT_MAX = 20;
    localparam int STL_F_PCT_MAX = 10;
    localparam int STL_PCT_FULL = 100;
    localparam int STL_HYST_PCT = 20;

    // ==========================================================
    // Timing
    localparam int STL_CLK_HZ = 40000000;
    localparam int STL_OFF_MS_DEF = 750;
    localparam int STL_MS_PER_S = 1000;
    localparam int STL_OFF_CYC_DEF = STL_CLK_HZ / STL_MS_PER_S * STL_OFF_MS_DEF;

    // ==========================================================
    // Configuration bundle (panel or local)
    typedef struct packed {
        logic preferred_src;
        logic [STL_VW-1:0] rated_voltage;
        logic [STL_FW-1:0] rated_frequency;
        logic [3:0] volt_step;
        logic [3:0] freq_step;
        logic delayed_en;
        logic [STL_QW-1:0] qual_cycles;
        logic [STL_QW-1:0] off_cycles;
    } stl_cfg_t;

    typedef struct packed {
        logic [STL_VW-1:0] volt;
        logic [STL_FW-1:0] freq;
    } stl_meas_t;

    typedef enum logic [2:0] {
        STL_ON_PREF = 3'h0,
        STL_OPEN_PREF = 3'h1,
        STL_WAIT_ALT = 3'h3,
        STL_ON_ALT = 3'h2,
        STL_OPEN_ALT = 3'h6,
        STL_WAIT_PREF = 3'h4
    } stl_state_t;

endpackage

// File: rtl/stl_transfer.sv
// Source monitor with dropout qualification and break-before-make transfer.
// Measurements and configuration are synchronous to clock; the switch
// mechanism reports contact position through two feedback levels.
module stl_transfer
    import stl_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire stl_cfg_t dip_cfg,
    input wire stl_cfg_t panel_cfg,
    input wire logic panel_present,
    input wire stl_meas_t meas_a,
    input wire stl_meas_t meas_b,
    input wire logic closed_a,
    input wire logic closed_b,
    output logic close_a,
    output logic close_b,
    output logic fault_a,
    output logic fault_b,
    output logic on_alt,
    output stl_cfg_t active_cfg
);

    // ==========================================================
    // Configuration select
    stl_cfg_t cfg_r;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cfg_r <= '0;
        else
            cfg_r <= panel_present ? panel_cfg : dip_cfg;
    end
    assign active_cfg = cfg_r;

    // ==========================================================
    // Contact feedback synchronisers
    // Auxiliary contacts are not timed to clock; only the second flop is read
    logic [1:0] fb_a_r;
    logic [1:0] fb_b_r;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            fb_a_r <= '0;
            fb_b_r <= '0;
        end
        else
        begin
            fb_a_r <= {fb_a_r[0], closed_a};
            fb_b_r <= {fb_b_r[0], closed_b};
        end
    end

    // ==========================================================
    // Threshold derivation
    logic [5:0] vpct;
    logic [5:0] fpct;
    logic [STL_VW+6:0] vprod;
    logic [STL_FW+6:0] fprod;
    logic [STL_VW-1:0] voff;
    logic [STL_FW-1:0] foff;
    logic [STL_VW-1:0] vhys;
    logic [STL_FW-1:0] fhys;
    always_comb
    begin
        vpct = 6'(STL_V_PCT_BASE + STL_V_PCT_STEP * int'(cfg_r.volt_step));
        if (vpct > 6'(STL_V_PCT_MAX))
            vpct = 6'(STL_V_PCT_MAX);
        fpct = 6'(STL_F_PCT_BASE + STL_F_PCT_STEP * int'(cfg_r.freq_step));
        if (fpct > 6'(STL_F_PCT_MAX))
            fpct = 6'(STL_F_PCT_MAX);
        vprod = (STL_VW+7)'(cfg_r.rated_voltage * vpct);
        fprod = (STL_FW+7)'(cfg_r.rated_frequency * fpct);
        voff = STL_VW'(vprod / STL_PCT_FULL);
        foff = STL_FW'(fprod / STL_PCT_FULL);
        vhys = STL_VW'(voff * STL_HYST_PCT / STL_PCT_FULL);
        fhys = STL_FW'(foff * STL_HYST_PCT / STL_PCT_FULL);
    end

    // Levels: under dropout, under pickup, over pickup, over dropout
    logic [STL_VW-1:0] v_ud, v_up, v_op, v_od;
    logic [STL_FW-1:0] f_ud, f_up, f_op, f_od;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            v_ud <= '0;
            v_up <= '0;
            v_op <= '1;
            v_od <= '1;
            f_ud <= '0;
            f_up <= '0;
            f_op <= '1;
            f_od <= '1;
        end
        else
        begin
            v_ud <= cfg_r.rated_voltage - voff;
            v_up <= cfg_r.rated_voltage - voff + vhys;
            v_od <= cfg_r.rated_voltage + voff;
            v_op <= cfg_r.rated_voltage + voff - vhys;
            f_ud <= cfg_r.rated_frequency - foff;
            f_up <= cfg_r.rated_frequency - foff + fhys;
            f_od <= cfg_r.rated_frequency + foff;
            f_op <= cfg_r.rated_frequency + foff - fhys;
        end
    end

    // ==========================================================
    // Per-source monitors
    logic [STL_QW-1:0] qcnt_r [2];
    // Levels hold stale values for two edges after reset; judge nothing then
    logic [1:0] lvl_vld_r;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            lvl_vld_r <= '0;
        else
            lvl_vld_r <= {lvl_vld_r[0], 1'b1};
    end
    logic fault_r [2];
    stl_meas_t m [2];
    assign m[0] = meas_a;
    assign m[1] = meas_b;

    for (genvar s = 0; s < 2; s++)
    begin : g_mon
        logic beyond;
        logic inside_pick;
        always_comb
        begin
            beyond = lvl_vld_r[1] && ((m[s].volt < v_ud) || (m[s].volt > v_od)
                || (m[s].freq < f_ud) || (m[s].freq > f_od));
            inside_pick = (m[s].volt >= v_up) && (m[s].volt <= v_op)
                && (m[s].freq >= f_up) && (m[s].freq <= f_op);
        end
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                qcnt_r[s] <= '0;
                fault_r[s] <= 1'b0;
            end
            else if (!fault_r[s])
            begin
                if (!beyond)
                    qcnt_r[s] <= '0;
                else if (qcnt_r[s] >= cfg_r.qual_cycles)
                    fault_r[s] <= 1'b1;
                else
                    qcnt_r[s] <= qcnt_r[s] + 1'b1;
            end
            else if (inside_pick)
            begin
                fault_r[s] <= 1'b0;
                qcnt_r[s] <= '0;
            end
        end
        chk_fault_after_qual: assert property (@(posedge clock) disable iff (rst)
            $rose(fault_r[s]) |-> $past(beyond) && $past(qcnt_r[s]) >= $past(cfg_r.qual_cycles))
            else $error("fault set without qualification");
        chk_timer_restart: assert property (@(posedge clock) disable iff (rst)
            !fault_r[s] && !beyond |=> qcnt_r[s] == '0)
            else $error("qualification timer not cleared");
        chk_fault_pickup: assert property (@(posedge clock) disable iff (rst)
            $fell(fault_r[s]) |-> $past(inside_pick))
            else $error("fault cleared outside pickup");
    end
    assign fault_a = fault_r[0];
    assign fault_b = fault_r[1];

    // ==========================================================
    // Transfer sequencer
    stl_state_t st_r, st_nxt;
    logic [STL_QW-1:0] off_r;
    logic pref_bad, alt_bad, pref_closed, alt_closed, off_done;
    always_comb
    begin
        pref_bad = cfg_r.preferred_src ? fault_r[1] : fault_r[0];
        alt_bad = cfg_r.preferred_src ? fault_r[0] : fault_r[1];
        pref_closed = cfg_r.preferred_src ? fb_b_r[1] : fb_a_r[1];
        alt_closed = cfg_r.preferred_src ? fb_a_r[1] : fb_b_r[1];
        off_done = !cfg_r.delayed_en || off_r >= cfg_r.off_cycles;
        st_nxt = st_r;
        case (st_r)
            // An on state is left only once its contact reports closed, so a
            // close still in travel is never taken for an open contact
            STL_ON_PREF:
                if (pref_bad && !alt_bad && pref_closed)
                    st_nxt = STL_OPEN_PREF;
            STL_OPEN_PREF: if (!pref_closed && !alt_closed) st_nxt = STL_WAIT_ALT;
            STL_WAIT_ALT: if (off_done) st_nxt = STL_ON_ALT;
            STL_ON_ALT:
                if ((!pref_bad || alt_bad) && alt_closed)
                    st_nxt = STL_OPEN_ALT;
            STL_OPEN_ALT: if (!pref_closed && !alt_closed) st_nxt = STL_WAIT_PREF;
            STL_WAIT_PREF: if (off_done) st_nxt = STL_ON_PREF;
            default: st_nxt = STL_ON_PREF;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_r <= STL_ON_PREF;
        else
            st_r <= st_nxt;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            off_r <= '0;
        else if (st_r == STL_WAIT_ALT || st_r == STL_WAIT_PREF)
            off_r <= off_r + 1'b1;
        else
            off_r <= '0;
    end

    logic close_pref_r, close_alt_r;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            close_pref_r <= 1'b0;
            close_alt_r <= 1'b0;
        end
        else
        begin
            close_pref_r <= (st_nxt == STL_ON_PREF);
            close_alt_r <= (st_nxt == STL_ON_ALT);
        end
    end
    assign close_a = cfg_r.preferred_src ? close_alt_r : close_pref_r;
    assign close_b = cfg_r.preferred_src ? close_pref_r : close_alt_r;
    assign on_alt = close_alt_r;

    chk_break_before: assert property (@(posedge clock) disable iff (rst)
        !(close_pref_r && close_alt_r))
        else $error("both sources commanded closed");
    chk_make_after_open: assert property (@(posedge clock) disable iff (rst)
        $rose(close_alt_r) |-> $past(!pref_closed && !alt_closed))
        else $error("alternate closed before preferred opened");
    chk_off_time: assert property (@(posedge clock) disable iff (rst)
        $rose(close_alt_r) && cfg_r.delayed_en |-> $past(off_r) >= $past(cfg_r.off_cycles))
        else $error("off interval too short");
    chk_panel_wins: assert property (@(posedge clock) disable iff (rst)
        panel_present |=> cfg_r == $past(panel_cfg))
        else $error("panel config not taken");

    cov_transfer: cover property (@(posedge clock) disable iff (rst) $rose(close_alt_r));
    cov_return: cover property (@(posedge clock) disable iff (rst)
        st_r == STL_WAIT_PREF ##1 st_r == STL_ON_PREF);
    cov_fault_a: cover property (@(posedge clock) disable iff (rst) $rose(fault_r[0]));
    cov_delayed: cover property (@(posedge clock) disable iff (rst)
        cfg_r.delayed_en && st_r == STL_WAIT_ALT ##1 st_r == STL_ON_ALT);

endmodule

// File: test/stl_switch_model.sv
// Switch mechanism model: contact feedback trails the close commands.
// Assumes level commands on clock; each contact moves after three cycles.
module stl_switch_model
(
    input wire logic clock,
    input wire logic rst,
    input wire logic close_a,
    input wire logic close_b,
    output logic closed_a,
    output logic closed_b
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Contact travel
    logic [2:0] trav_a_r;
    logic [2:0] trav_b_r;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            trav_a_r <= 3'h0;
            trav_b_r <= 3'h0;
        end
        else
        begin
            trav_a_r <= {trav_a_r[1:0], close_a};
            trav_b_r <= {trav_b_r[1:0], close_b};
        end
    end
    assign closed_a = trav_a_r[2];
    assign closed_b = trav_b_r[2];
endmodule

// File: test/stl_transfer_tb_top.sv
// Self-checking bench for the source monitor and transfer logic.
// Assumes the switch model on the contacts, 400/500 rated units in the local config and 230/500 in the panel config.
module stl_transfer_tb_top
    import stl_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst, panel_present, close_a, close_b, closed_a, closed_b;
    logic fault_a, fault_b, on_alt;
    stl_cfg_t dip_cfg, panel_cfg, active_cfg;
    stl_meas_t meas_a, meas_b;
    int miscompares = 0;
    int n_checks = 0;
    stl_transfer dut_u (.clock(clock), .rst(rst), .dip_cfg(dip_cfg),
        .panel_cfg(panel_cfg), .panel_present(panel_present), .meas_a(meas_a),
        .meas_b(meas_b), .closed_a(closed_a), .closed_b(closed_b),
        .close_a(close_a), .close_b(close_b), .fault_a(fault_a),
        .fault_b(fault_b), .on_alt(on_alt), .active_cfg(active_cfg));
    stl_switch_model sw_u (.clock(clock), .rst(rst), .close_a(close_a),
        .close_b(close_b), .closed_a(closed_a), .closed_b(closed_b));
    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [127:0] exp,
        input logic [127:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic drive(input logic [15:0] v, input logic [15:0] f);
        @(posedge clock);
        meas_a <= {v, f};
    endtask
    task automatic wait_on(input int sel, input logic exp, input int lim, output int n);
        n = 0;
        @(negedge clock);
        while ((sel == 0 ? fault_a : sel == 1 ? close_a : close_b) !== exp && n < lim)
        begin
            @(negedge clock);
            n++;
        end
        chk(sel == 0 ? "fault_a" : sel == 1 ? "close_a" : "close_b", exp,
            sel == 0 ? fault_a : sel == 1 ? close_a : close_b);
    endtask
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic trip_recover(input logic [15:0] vb, fb, vm, fm, vo, fo);
        int n;
        drive(vb, fb);
        wait_on(0, 1'b1, 12, n);
        drive(vm, fm);
        repeat (10) @(negedge clock);
        chk("fault_a held", 1'b1, fault_a);
        drive(vo, fo);
        wait_on(0, 1'b0, 4, n);
        drive(16'h0190, 16'h01f4);
        repeat (60) @(posedge clock);
    endtask
    task automatic qual_restart;
        drive(16'h0167, 16'h01f4);
        repeat (4) @(posedge clock);
        drive(16'h0190, 16'h01f4);
        repeat (4) @(posedge clock);
        drive(16'h0167, 16'h01f4);
        repeat (4) @(posedge clock);
        drive(16'h0190, 16'h01f4);
        repeat (10) @(negedge clock);
        chk("fault_a", 1'b0, fault_a);
    endtask
    task automatic transfer;
        int n;
        drive(16'h0167, 16'h01f4);
        repeat (3) @(negedge clock);
        chk("fault_a early", 1'b0, fault_a);
        wait_on(0, 1'b1, 12, n);
        wait_on(1, 1'b0, 4, n);
        wait_on(2, 1'b1, 40, n);
        chk("off gap", 1'b1, n >= 10);
        chk("on_alt", 1'b1, on_alt);
        drive(16'h0170, 16'h01f4);
        wait_on(1, 1'b1, 60, n);
        chk("on_alt", 1'b0, on_alt);
    endtask
    task automatic panel_trip;
        int n;
        @(posedge clock);
        panel_present <= 1'b1;
        repeat (3) @(negedge clock);
        chk("active_cfg", panel_cfg, active_cfg);
        wait_on(0, 1'b1, 12, n);
        chk("fault_b", 1'b1, fault_b);
        repeat (8) @(negedge clock);
        chk("close_a both bad", 1'b1, close_a);
        chk("on_alt both bad", 1'b0, on_alt);
        @(posedge clock);
        meas_a <= {16'h00e6, 16'h01f4};
        meas_b <= {16'h00e6, 16'h01f4};
        repeat (3) @(negedge clock);
        chk("fault_b", 1'b0, fault_b);
        drive(16'h00c8, 16'h01f4);
        wait_on(0, 1'b1, 12, n);
        wait_on(1, 1'b0, 4, n);
        wait_on(2, 1'b1, 40, n);
        chk("no off wait", 1'b1, n < 8);
    endtask
    // ==========================================================
    // Stimulus and watchdogs
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(negedge clock)
        if (!rst && ((close_a === 1'b1 && (close_b === 1'b1 || closed_b === 1'b1))
            || (close_b === 1'b1 && closed_a === 1'b1)))
            chk("make before break", 1'b0, 1'b1);
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
    initial
    begin
        rst = 1'b1;
        panel_present = 1'b0;
        // Scaled-down off time stands for the motor decay interval
        dip_cfg = {1'b0, 16'h0190, 16'h01f4, 4'h3, 4'h3, 1'b1, 32'h5, 32'ha};
        panel_cfg = {1'b0, 16'h00e6, 16'h01f4, 4'h2, 4'h1, 1'b0, 32'h3, 32'h4};
        meas_a = {16'h0190, 16'h01f4};
        meas_b = {16'h0190, 16'h01f4};
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(negedge clock);
        chk("close_a", 1'b1, close_a);
        chk("active_cfg", dip_cfg, active_cfg);
        qual_restart();
        transfer();
        trip_recover(16'h0167, 16'h01f4, 16'h016f, 16'h01f4, 16'h0170, 16'h01f4);
        trip_recover(16'h01b9, 16'h01f4, 16'h01b1, 16'h01f4, 16'h01b0, 16'h01f4);
        trip_recover(16'h0190, 16'h01da, 16'h0190, 16'h01df, 16'h0190, 16'h01e0);
        trip_recover(16'h0190, 16'h020e, 16'h0190, 16'h0209, 16'h0190, 16'h0208);
        panel_trip();
        give_verdict();
    end
endmodule
